//--- inc/swdt_regs.vh
// Watchdog register map, field positions, reset values and timing constants.
// Assumes inclusion by bare name from the watchdog design files.
`ifndef SWDT_REGS_VH
`define SWDT_REGS_VH

`define SWDT_ADDR_W 4
`define SWDT_A_MODE 4'h0
`define SWDT_A_TC 4'h1
`define SWDT_A_FEED 4'h2
`define SWDT_A_TV 4'h3
`define SWDT_A_IST 4'h4
`define SWDT_A_IEN 4'h5
`define SWDT_A_ICLR 4'h6

`define SWDT_MODE_EN 0
`define SWDT_MODE_RESET 1
`define SWDT_MODE_TOF 2
`define SWDT_MODE_INTF 3

`define SWDT_IST_EXPIRE 0
`define SWDT_IST_BADFEED 1
`define SWDT_IST_W 2

`define SWDT_FEED_KEY1 32'h0000_00AA
`define SWDT_FEED_KEY2 32'h0000_0055
`define SWDT_TC_MIN 32'h0000_0100
`define SWDT_TC_RESET 32'h0000_00FF
`define SWDT_PRESCALE 2'h3
`define SWDT_ZERO32 32'h0000_0000
`define SWDT_ONE32 32'h0000_0001

`endif

//--- verilog/swdt_prescale.v
// Fixed divide-by-four tick generator for the watchdog counter.
// Assumes a single clock mclk and a synchronous active-low reset.
`timescale 1ns/1ps
`include "swdt_regs.vh"

module swdt_prescale (
    mclk,
    rst_b,
    run,
    tick
);
    input wire mclk;
    input wire rst_b;
    input wire run;
    output wire tick;

    reg [1:0] div_reg;
    wire [1:0] div_next;

    // Restarts at every feed so each tick is a full four clocks
    assign div_next = run ? (div_reg + 2'h1) : 2'h0;
    assign tick = run && (div_reg == `SWDT_PRESCALE);

    always @(posedge mclk) begin
        if (!rst_b) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_next;
        end
    end
endmodule // swdt_prescale

//--- verilog/swdt_top.v
// System watchdog timer: 32-bit counter behind a divide-by-four prescaler,
// feed sequence checking, reset or interrupt on expiry.
// Assumes a register master on mclk with one-cycle strobes; wdt_reset_req
// is taken by the system reset logic, which then asserts rst_b.
//
// What this block does
// - While enabled in reset mode and armed by a feed, a missed reload before the timeout makes the watchdog request a system reset.
// - Each correct feed restarts the countdown from the programmed timeout value.
// - Software can set the enable but never clear it; only reset or a watchdog event clears it.
// - Software chooses reset or interrupt on expiry, and the watchdog disables itself after either.
// - A wrong or interrupted feed sequence while enabled and armed by a feed triggers the same response as expiry.
// - A readable flag records that the last reset was caused by the watchdog.
// - The timeout counter is 32 bits wide and advances once per prescaler tick.
// - The programmed timeout ranges from 256 to 2^32-1 ticks of four clocks, in steps of one tick.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "swdt_regs.vh"

module swdt_top (
    mclk,
    rst_b,
    por_b,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    wdt_reset_req,
    wdt_irq
);
    input wire mclk;
    input wire rst_b;
    input wire por_b;
    input wire [`SWDT_ADDR_W-1:0] reg_addr;
    input wire [31:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [31:0] reg_rdata;
    output reg wdt_reset_req;
    output wire wdt_irq;

    localparam ST_IDLE = 1'b0;
    localparam ST_HALF = 1'b1;

    reg en_reg;
    reg en_next;
    reg rst_mode_reg;
    reg rst_mode_next;
    reg tof_reg;
    reg tof_next;
    reg [31:0] tc_reg;
    reg [31:0] tc_next;
    reg [31:0] tv_reg;
    reg [31:0] tv_next;
    reg armed_reg;
    reg armed_next;
    reg feed_st_reg;
    reg feed_st_next;
    reg [`SWDT_IST_W-1:0] ist_reg;
    reg [`SWDT_IST_W-1:0] ist_next;
    reg [`SWDT_IST_W-1:0] ien_reg;
    reg [`SWDT_IST_W-1:0] ien_next;
    reg [31:0] rdata_next;
    reg rreq_next;
    reg feed_ok;
    reg feed_bad;
    reg expire;
    reg fire;

    wire tick;
    wire running;
    wire mode_wr;
    wire tc_wr;
    wire feed_wr;
    wire ien_wr;
    wire iclr_wr;
    wire any_acc;

    // Clamp programmed timeout to the smallest legal value
    function [31:0] clamp_tc;
        input [31:0] v;
        begin
            clamp_tc = (v < `SWDT_TC_MIN) ? `SWDT_TC_MIN : v;
        end
    endfunction

    function is_wr;
        input [`SWDT_ADDR_W-1:0] a;
        input [`SWDT_ADDR_W-1:0] target;
        input w;
        begin
            is_wr = w && (a == target);
        end
    endfunction

    assign running = en_reg && armed_reg;

    // Register strobe decode
    assign mode_wr = is_wr(reg_addr, `SWDT_A_MODE, reg_wr);
    assign tc_wr = is_wr(reg_addr, `SWDT_A_TC, reg_wr);
    assign feed_wr = is_wr(reg_addr, `SWDT_A_FEED, reg_wr);
    assign ien_wr = is_wr(reg_addr, `SWDT_A_IEN, reg_wr);
    assign iclr_wr = is_wr(reg_addr, `SWDT_A_ICLR, reg_wr);
    assign any_acc = reg_wr || reg_rd;

    swdt_prescale u_prescale (
        .mclk(mclk),
        .rst_b(rst_b),
        .run(running && !feed_ok),
        .tick(tick)
    );

    // Feed sequence checker
    always @* begin
        feed_ok = 1'b0;
        feed_bad = 1'b0;
        feed_st_next = feed_st_reg;
        case (feed_st_reg)
            ST_IDLE: begin
                if (feed_wr) begin
                    if (reg_wdata == `SWDT_FEED_KEY1) begin
                        feed_st_next = ST_HALF;
                    end else begin
                        feed_bad = 1'b1;
                    end
                end
            end
            ST_HALF: begin
                if (any_acc) begin
                    feed_st_next = ST_IDLE;
                    if (feed_wr && reg_wdata == `SWDT_FEED_KEY2) begin
                        feed_ok = 1'b1;
                    end else begin
                        feed_bad = 1'b1;
                    end
                end
            end
            default: begin
                feed_st_next = ST_IDLE;
            end
        endcase
    end

    // Expiry and feed faults share one response path
    always @* begin
        expire = running && tick && (tv_reg == `SWDT_ONE32);
        fire = expire || (running && feed_bad);
    end

    // Enable is set-only; besides reset, only the watchdog's own event clears it
    always @* begin
        en_next = en_reg;
        rst_mode_next = rst_mode_reg;
        if (mode_wr) begin
            en_next = en_reg | reg_wdata[`SWDT_MODE_EN];
            rst_mode_next = reg_wdata[`SWDT_MODE_RESET];
        end
        if (fire) begin
            en_next = 1'b0;
        end
    end

    // Reset cause flag: set by a watchdog reset, set beats clear
    always @* begin
        tof_next = tof_reg;
        if (mode_wr && !reg_wdata[`SWDT_MODE_TOF]) begin
            tof_next = 1'b0;
        end
        if (fire && rst_mode_reg) begin
            tof_next = 1'b1;
        end
    end

    // Timeout value, clamped to the shortest legal interval
    always @* begin
        tc_next = tc_reg;
        if (tc_wr) begin
            tc_next = clamp_tc(reg_wdata);
        end
    end

    // Countdown: reloaded by a good feed, one step per tick
    always @* begin
        tv_next = tv_reg;
        armed_next = armed_reg;
        if (feed_ok) begin
            tv_next = tc_reg;
            armed_next = en_reg;
        end else if (running && tick) begin
            tv_next = tv_reg - `SWDT_ONE32;
        end
        if (fire) begin
            armed_next = 1'b0;
        end
    end

    // Interrupt status: hardware set wins over software clear
    always @* begin
        ist_next = ist_reg;
        if (iclr_wr) begin
            ist_next = ist_reg & ~reg_wdata[`SWDT_IST_W-1:0];
        end
        if (fire && !rst_mode_reg) begin
            ist_next[`SWDT_IST_EXPIRE] = ist_next[`SWDT_IST_EXPIRE] | expire;
            ist_next[`SWDT_IST_BADFEED] = ist_next[`SWDT_IST_BADFEED] | !expire;
        end
    end

    // Chip reset request only in reset mode
    always @* begin
        rreq_next = fire && rst_mode_reg;
    end

    // Interrupt enable mask
    always @* begin
        ien_next = ien_reg;
        if (ien_wr) begin
            ien_next = reg_wdata[`SWDT_IST_W-1:0];
        end
    end

    assign wdt_irq = |(ist_reg & ien_reg);

    // Read mux
    always @* begin
        rdata_next = `SWDT_ZERO32;
        if (reg_rd) begin
            case (reg_addr)
                `SWDT_A_MODE: begin
                    rdata_next[`SWDT_MODE_EN] = en_reg;
                    rdata_next[`SWDT_MODE_RESET] = rst_mode_reg;
                    rdata_next[`SWDT_MODE_TOF] = tof_reg;
                    rdata_next[`SWDT_MODE_INTF] = |ist_reg;
                end
                `SWDT_A_TC: rdata_next = tc_reg;
                `SWDT_A_TV: rdata_next = tv_reg;
                `SWDT_A_IST: rdata_next[`SWDT_IST_W-1:0] = ist_reg;
                `SWDT_A_IEN: rdata_next[`SWDT_IST_W-1:0] = ien_reg;
                default: rdata_next = `SWDT_ZERO32;
            endcase
        end
    end

    // The watchdog flag survives a watchdog reset; only power-on or a mode write with the flag bit low clears it
    always @(posedge mclk) begin
        if (!por_b) begin
            tof_reg <= 1'b0;
        end else begin
            tof_reg <= tof_next;
        end
    end

    // Mode and enable
    always @(posedge mclk) begin
        if (!rst_b) begin
            en_reg <= 1'b0;
            rst_mode_reg <= 1'b0;
        end else begin
            en_reg <= en_next;
            rst_mode_reg <= rst_mode_next;
        end
    end

    always @(posedge mclk) begin
        if (!rst_b) begin
            tc_reg <= `SWDT_TC_RESET;
            tv_reg <= `SWDT_TC_RESET;
            armed_reg <= 1'b0;
        end else begin
            tc_reg <= tc_next;
            tv_reg <= tv_next;
            armed_reg <= armed_next;
        end
    end

    // Feed sequence state
    always @(posedge mclk) begin
        if (!rst_b) begin
            feed_st_reg <= ST_IDLE;
        end else begin
            feed_st_reg <= feed_st_next;
        end
    end

    always @(posedge mclk) begin
        if (!rst_b) begin
            ist_reg <= {`SWDT_IST_W{1'b0}};
            ien_reg <= {`SWDT_IST_W{1'b0}};
        end else begin
            ist_reg <= ist_next;
            ien_reg <= ien_next;
        end
    end

    // Read data stands for exactly one cycle after the strobe
    always @(posedge mclk) begin
        if (!rst_b) begin
            reg_rdata <= `SWDT_ZERO32;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    // One-cycle reset request to the system reset logic
    always @(posedge mclk) begin
        if (!rst_b) begin
            wdt_reset_req <= 1'b0;
        end else begin
            wdt_reset_req <= rreq_next;
        end
    end
endmodule // swdt_top

//--- bench/swdt_asserts.sv
// Port checker for the watchdog top level.
// Assumes one clock mclk and a synchronous active-low rst_b.
`timescale 1ns/1ps
`include "swdt_regs.vh"
module swdt_chk (
    input wire mclk,
    input wire rst_b,
    input wire por_b,
    input wire [`SWDT_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire wdt_reset_req,
    input wire wdt_irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire iclr = reg_wr && reg_addr == `SWDT_A_ICLR && reg_wdata[1:0] == 2'h3;
    wire mask = reg_wr && reg_addr == `SWDT_A_IEN && reg_wdata[1:0] == 2'h0;
    wire k1 = reg_wr && reg_addr == `SWDT_A_FEED && reg_wdata == `SWDT_FEED_KEY1;
    wire k2 = reg_wr && reg_addr == `SWDT_A_FEED && reg_wdata == `SWDT_FEED_KEY2;
    chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == `SWDT_ZERO32)
        else $error("read data not zero");
    chk_rd_unmapped: assert property ($past(reg_rd && reg_addr > `SWDT_A_ICLR) |-> reg_rdata == `SWDT_ZERO32)
        else $error("unmapped read not zero");
    chk_req_pulse: assert property (wdt_reset_req |=> !wdt_reset_req [*3])
        else $error("reset request repeated");
    chk_rst_quiet: assert property ($rose(rst_b) |-> !wdt_irq && !wdt_reset_req)
        else $error("outputs active after reset");
    chk_feed_hold: assert property ($past(k1, 2) && !$past(reg_wr || reg_rd) && k2 |=> !wdt_reset_req [*4])
        else $error("reset request after good feed");
    chk_iclr_low: assert property (iclr |=> !wdt_irq)
        else $error("interrupt held after clear");
    chk_ien_mask: assert property (mask |=> !wdt_irq)
        else $error("interrupt not masked");
    chk_irq_excl: assert property ($rose(wdt_irq) |-> !wdt_reset_req && !$past(wdt_reset_req))
        else $error("interrupt and reset together");
endmodule // swdt_chk
bind swdt_top swdt_chk u_chk (.mclk(mclk), .rst_b(rst_b), .por_b(por_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wdt_reset_req(wdt_reset_req), .wdt_irq(wdt_irq));

//--- bench/swdt_top_tb.sv
// Self-checking bench for the watchdog: bus, feed, expiry, interrupt.
// Assumes swdt_regs.vh on the include path.
`timescale 1ns/1ps
`include "swdt_regs.vh"
module swdt_top_tb;
    reg mclk, rst_b, por_b, reg_wr, reg_rd;
    reg [3:0] reg_addr;
    reg [31:0] reg_wdata, rv;
    wire [31:0] reg_rdata;
    wire wdt_reset_req, wdt_irq;
    integer miscompares, checks, seed, n, i;
    integer cyc = 0;
    swdt_top uut (.mclk(mclk), .rst_b(rst_b), .por_b(por_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wdt_reset_req(wdt_reset_req), .wdt_irq(wdt_irq));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task print_verdict;
        begin
            $display("checks %0d miscompares %0d", checks, miscompares);
            if (miscompares == 0 && checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 15000) begin
            miscompares = miscompares + 1;
            print_verdict;
        end
    end
    task check(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        begin
            @(posedge mclk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge mclk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [31:0] m, input [31:0] exp);
        begin
            @(posedge mclk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge mclk);
            reg_rd <= 1'b0;
            @(negedge mclk);
            check(reg_rdata & m, exp);
        end
    endtask
    task feed;
        begin
            wr(`SWDT_A_FEED, `SWDT_FEED_KEY1);
            wr(`SWDT_A_FEED, `SWDT_FEED_KEY2);
        end
    endtask
    // Cycles until interrupt or reset request
    task wait_event(output integer cnt);
        begin
            cnt = 0;
            while (wdt_irq !== 1'b1 && wdt_reset_req !== 1'b1 && cnt < 5000) begin
                @(negedge mclk);
                cnt = cnt + 1;
            end
        end
    endtask
    function [31:0] clamp(input [31:0] v);
        clamp = (v < `SWDT_TC_MIN) ? `SWDT_TC_MIN : v;
    endfunction
    function [31:0] in_win(input integer got, input integer lo, input integer hi);
        in_win = (got >= lo && got <= hi) ? `SWDT_ONE32 : `SWDT_ZERO32;
    endfunction
    initial begin
        seed = 72555;
        miscompares = 0;
        checks = 0;
        {rst_b, por_b, reg_wr, reg_rd, reg_addr, reg_wdata} <= 40'h0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        rd(`SWDT_A_MODE, 32'h0000_000F, `SWDT_ZERO32);
        rd(`SWDT_A_TC, 32'hFFFF_FFFF, `SWDT_TC_RESET);
        for (i = 7; i < 16; i = i + 1)
            rd(i[3:0], 32'hFFFF_FFFF, `SWDT_ZERO32);
        rv = $random(seed) & 32'h0000_00FF;
        wr(`SWDT_A_TC, rv);
        rd(`SWDT_A_TC, 32'hFFFF_FFFF, clamp(rv));
        wr(`SWDT_A_IEN, 32'h0000_0003);
        wr(`SWDT_A_MODE, 32'h0000_0001);
        wr(`SWDT_A_MODE, 32'h0000_0000);
        rd(`SWDT_A_MODE, 32'h0000_0001, `SWDT_ONE32);
        feed;
        wait_event(n);
        check(in_win(n, 1021, 1027), `SWDT_ONE32);
        check({31'h0, wdt_reset_req}, `SWDT_ZERO32);
        rd(`SWDT_A_IST, 32'h0000_0003, `SWDT_ONE32);
        rd(`SWDT_A_MODE, 32'h0000_000F, 32'h0000_0008);
        wr(`SWDT_A_IEN, 32'h0000_0000);
        wr(`SWDT_A_IEN, 32'h0000_0003);
        @(negedge mclk);
        check({31'h0, wdt_irq}, `SWDT_ONE32);
        wr(`SWDT_A_ICLR, 32'h0000_0003);
        wr(`SWDT_A_MODE, 32'h0000_0001);
        for (i = 0; i < 6; i = i + 1) begin
            feed;
            rd(`SWDT_A_TV, 32'hFFFF_FFFF, `SWDT_TC_MIN);
            repeat (($random(seed) & 32'h0000_01FF) + 400) @(posedge mclk);
            @(negedge mclk);
            check({31'h0, wdt_irq}, `SWDT_ZERO32);
        end
        for (i = 0; i < 2; i = i + 1) begin
            wr(`SWDT_A_MODE, 32'h0000_0001);
            feed;
            if (i == 0) begin
                wr(`SWDT_A_FEED, `SWDT_FEED_KEY1);
                wr(`SWDT_A_TC, `SWDT_TC_MIN);
            end else
                wr(`SWDT_A_FEED, {$random(seed)} | 32'h0000_0100);
            wait_event(n);
            check(in_win(n, 0, 3), `SWDT_ONE32);
            rd(`SWDT_A_IST, 32'h0000_0003, 32'h0000_0002);
            wr(`SWDT_A_ICLR, 32'h0000_0003);
        end
        wr(`SWDT_A_MODE, 32'h0000_0003);
        feed;
        wait_event(n);
        check(in_win(n, 1021, 1027) & {31'h0, wdt_reset_req}, `SWDT_ONE32);
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        rd(`SWDT_A_MODE, 32'h0000_000F, 32'h0000_0004);
        rv = {$random(seed)} | 32'h8000_0000;
        wr(`SWDT_A_TC, rv);
        rd(`SWDT_A_TC, 32'hFFFF_FFFF, rv);
        wr(`SWDT_A_MODE, 32'h0000_0000);
        rd(`SWDT_A_MODE, 32'h0000_000F, `SWDT_ZERO32);
        print_verdict;
    end
endmodule // swdt_top_tb
